// >>> rtl/hp_slot_cfg.svh
// constants for the hot plug slot controller: offsets, field positions,
// reset values and serial timing counts.
// assumes a 40 MHz bridge clock; included by bare name, definitions only.
`ifndef HP_SLOT_CFG_SVH
`define HP_SLOT_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HP_SCLK_KHZ      8330
`define HP_CLK_PERIOD_NS 25

// ----------------------------------------------------------------
// inbound frame layout
// ----------------------------------------------------------------
`define HP_IN_LEN        6'd34
`define HP_IN_START      6'd1
`define HP_IN_CHAN0      6'd2
`define HP_IN_CHAN1      6'd3
`define HP_IN_BASE       5
`define HP_SLOT_STRIDE   8
`define HP_IB_PRSNT2     3
`define HP_IB_PRSNT1     4
`define HP_IB_M66        0
`define HP_IB_PCIX       1

// ----------------------------------------------------------------
// outbound frame layout, per-slot field positions
// ----------------------------------------------------------------
`define HP_OUT_LEN       5'd30
`define HP_OB_PWR        0
`define HP_OB_CLKEN      1
`define HP_OB_BUSEN      2
`define HP_OB_RSTN       3
`define HP_OB_PWRLED     4
`define HP_OB_FIELDS     6
`define HP_SLOTS         4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HP_M66_OE_RST    2'b11
`define HP_HOLD_LOW_RST  2'b11

`endif

// >>> rtl/hp_slot_pkg.sv
// types shared by the hot plug slot controller files.
// assumes nothing of its surroundings.
package hp_slot_pkg;

	// ------------------------------------------------------------
	// slot commands, one per bridge command port
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_POWER_ONLY,
		CMD_SLOT_ENABLE,
		CMD_SLOT_DISABLE,
		CMD_SET_SPEED
	} cmd_e;

	// ------------------------------------------------------------
	// outbound shifter states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OUT_IDLE,
		OUT_SHIFT,
		OUT_STROBE
	} out_state_e;

endpackage : hp_slot_pkg

// >>> rtl/hp_sync2.sv
// two-flop synchroniser for a group of independent pin levels.
// assumes each bit is a slow level; no bus coherence is given.
`timescale 1ns/100ps
module hp_sync2 #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk,
	// pins and synchronised copies
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s st;
	sync_s next_st;

	// first stage feeds only the second stage
	always_comb begin
		next_st.s1 = pin;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign level = st.s2;

endmodule : hp_sync2

// >>> rtl/hp_tick_div.sv
// divider giving a one-cycle enable pulse every HALF clock cycles.
// assumes a synchronous active-high reset on the same clock.
`timescale 1ns/100ps
module hp_tick_div #(
	parameter int HALF = 3
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// half-period enable
	output logic      tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} div_s;

	div_s st;
	div_s next_st;

	// count down, pulse on wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (rst) begin
			next_st = '0;
		end else if (st.cnt == 8'h00) begin
			next_st.cnt = 8'(HALF - 1);
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign tick = st.tick;

endmodule : hp_tick_div

// >>> rtl/hp_slot_ctrl.sv
// hot plug slot control for two bridges sharing one serial link to
// the external dual-slot power controllers.
// assumes command ports and bus reset come from logic on clk; serial
// input data and straps are pins and are synchronised here.
`timescale 1ns/100ps
`include "hp_slot_cfg.svh"
module hp_slot_ctrl (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// shared serial pins, strap inputs during reset
	input  wire logic                hp_serial_out_data_in,
	output logic                     hp_serial_out_data,
	output logic                     hp_serial_out_data_oe,
	input  wire logic                hp_serial_in_load_n_in,
	output logic                     hp_serial_in_load_n,
	output logic                     hp_serial_in_load_n_oe,
	input  wire logic                hp_serial_in_clock_in,
	output logic                     hp_serial_in_clock,
	output logic                     hp_serial_in_clock_oe,
	output logic                     hp_serial_out_clock,
	input  wire logic                bridge_b_grant2_strap,
	// per-bridge serial pins, index 0 bridge a, 1 bridge b
	input  wire logic [1:0]          hp_serial_in_data,
	output logic      [1:0]          output_latch_strobe,
	output logic      [1:0]          slot_reset_latch_strobe,
	input  wire logic [1:0]          sec_bus_reset,
	output logic      [1:0]          slot_reset_latch_clear_n,
	// command ports
	input  wire logic [1:0]          cmd_valid,
	input  hp_slot_pkg::cmd_e [1:0]  cmd_code,
	input  wire logic [1:0][1:0]     cmd_slot,
	input  wire logic [1:0]          cmd_mode_33,
	output logic      [1:0]          cmd_busy,
	// 66 MHz enable pins, open drain
	output logic      [1:0]          m66en_out,
	output logic      [1:0]          m66en_oe,
	// single-slot isolation controls
	output logic      [1:0]          slot_signals_hold_low,
	output logic      [1:0]          slot_bus_drive_en,
	// configuration and slot status
	output logic      [1:0]          hp_enabled,
	output logic      [1:0]          single_slot_strap_status_n,
	output logic      [1:0][3:0]     slot_prsnt1_n,
	output logic      [1:0][3:0]     slot_prsnt2_n,
	output logic      [1:0][3:0]     slot_66mhz_capability,
	output logic      [1:0][3:0][1:0] slot_pcix_capability,
	output logic      [1:0]          status_update
);
	import hp_slot_pkg::*;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	// half period rounded up so the link never runs above its rate
	localparam int SCLK_DEN = 2 * `HP_SCLK_KHZ * `HP_CLK_PERIOD_NS;
	localparam int HALF_CYC = (1000000 + SCLK_DEN - 1) / SCLK_DEN;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]            strap_hp;
		logic [1:0]            strap_ss_n;
		logic                  pins_oe;
		logic                  sclk;
		logic [5:0]            in_cnt;
		logic                  in_chan;
		logic                  load_n;
		logic [1:0][33:0]      in_buf;
		logic [1:0][3:0]       prsnt1_n;
		logic [1:0][3:0]       prsnt2_n;
		logic [1:0][3:0]       cap66;
		logic [1:0][3:0][1:0]  pcix;
		logic [1:0]            upd;
		out_state_e            ostate;
		logic                  obr;
		logic [4:0]            ocnt;
		logic                  odat;
		logic [1:0]            strobe;
		logic [1:0]            pending;
		logic [1:0][3:0]       pwr;
		logic [1:0][3:0]       clken;
		logic [1:0][3:0]       busen;
		logic [1:0][3:0]       rstn;
		logic [1:0]            mode33;
		logic [1:0]            m66_oe;
		logic [1:0]            hold_low;
		logic [1:0]            bus_drv;
		logic [1:0]            clr_n;
	} st_s;

	st_s        st;
	st_s        next_st;
	logic       tick;
	logic [5:0] sync_lv;
	logic       fall;

	// ------------------------------------------------------------
	// pin synchronisers and serial clock divider
	// ------------------------------------------------------------
	hp_sync2 #(
		.W (6)
	) u_sync (
		.clk   (clk),
		.pin   ({hp_serial_in_data, bridge_b_grant2_strap,
		         hp_serial_in_clock_in, hp_serial_in_load_n_in,
		         hp_serial_out_data_in}),
		.level (sync_lv)
	);

	hp_tick_div #(
		.HALF (HALF_CYC)
	) u_div (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	assign fall = tick & st.sclk;

	// outbound frame bit: slot 3 first, five fields then three spare, only one spare after slot 0
	function automatic logic out_bit(input st_s s, input logic b,
	                                 input logic [4:0] idx);
		logic [1:0] slot;
		logic [2:0] fld;
		logic       v;
		slot = 2'(3 - idx[4:3]);
		fld  = idx[2:0];
		case (fld)
			3'h0:    v = s.pwr[b][slot];
			3'h1:    v = s.clken[b][slot];
			3'h2:    v = s.busen[b][slot];
			3'h3:    v = s.rstn[b][slot];
			3'h4:    v = s.pwr[b][slot];
			default: v = 1'b0;
		endcase
		return v;
	endfunction : out_bit

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.upd = 2'b00;
		if (rst) begin
			next_st = '0;
			next_st.load_n = 1'b1;
			next_st.m66_oe = `HP_M66_OE_RST;
			next_st.hold_low = `HP_HOLD_LOW_RST;
			next_st.prsnt1_n = '1;
			next_st.prsnt2_n = '1;
			// straps are read while the pins float in reset
			next_st.strap_hp = sync_lv[1:0];
			next_st.strap_ss_n = sync_lv[3:2];
		end else begin
			next_st.pins_oe = 1'b1;
			if (tick) begin
				next_st.sclk = ~st.sclk;
			end

			// inbound: continuous, channels alternate
			if (fall && (st.strap_hp != 2'b00)) begin
				for (int b = 0; b < 2; b++) begin
					if (st.in_cnt >= 6'(`HP_IN_BASE)) begin
						next_st.in_buf[b][st.in_cnt] = sync_lv[4 + b];
					end
				end
				if (st.in_cnt == `HP_IN_LEN - 6'd1) begin
					next_st.in_cnt = 6'd0;
					next_st.in_chan = ~st.in_chan;
					next_st.upd = st.strap_hp;
					// decode the finished block
					for (int b = 0; b < 2; b++) begin
						for (int s = 0; s < `HP_SLOTS; s++) begin
							if (!st.in_chan) begin
								next_st.prsnt2_n[b][s] = next_st.in_buf[b]
								  [`HP_IN_BASE + s*`HP_SLOT_STRIDE
								   + `HP_IB_PRSNT2];
								next_st.prsnt1_n[b][s] = next_st.in_buf[b]
								  [`HP_IN_BASE + s*`HP_SLOT_STRIDE
								   + `HP_IB_PRSNT1];
							end else begin
								next_st.cap66[b][s] = next_st.in_buf[b]
								  [`HP_IN_BASE + s*`HP_SLOT_STRIDE
								   + `HP_IB_M66];
								next_st.pcix[b][s] = next_st.in_buf[b]
								  [`HP_IN_BASE + s*`HP_SLOT_STRIDE
								   + `HP_IB_PCIX +: 2];
							end
						end
					end
				end else begin
					next_st.in_cnt = st.in_cnt + 6'd1;
				end
				// load low marks start and the channel number
				case (next_st.in_cnt)
					`HP_IN_START: next_st.load_n = 1'b0;
					`HP_IN_CHAN0: next_st.load_n = next_st.in_chan;
					`HP_IN_CHAN1: next_st.load_n = 1'b0;
					default:      next_st.load_n = 1'b1;
				endcase
			end

			// commands, one port per bridge; ignored while busy
			for (int b = 0; b < 2; b++) begin
				logic [1:0] sl;
				sl = st.strap_ss_n[b] ? cmd_slot[b] : 2'd0;
				if (cmd_valid[b] && st.strap_hp[b]
				    && !st.pending[b]) begin
					case (cmd_code[b])
						CMD_POWER_ONLY: begin
							next_st.pwr[b][sl] = 1'b1;
							next_st.pending[b] = 1'b1;
						end
						CMD_SLOT_ENABLE: begin
							next_st.pwr[b][sl] = 1'b1;
							next_st.clken[b][sl] = 1'b1;
							next_st.busen[b][sl] = 1'b1;
							next_st.rstn[b][sl] = 1'b1;
							next_st.pending[b] = 1'b1;
						end
						CMD_SLOT_DISABLE: begin
							next_st.pwr[b][sl] = 1'b0;
							next_st.clken[b][sl] = 1'b0;
							next_st.busen[b][sl] = 1'b0;
							next_st.rstn[b][sl] = 1'b0;
							next_st.pending[b] = 1'b1;
						end
						CMD_SET_SPEED: begin
							next_st.mode33[b] = cmd_mode_33[b];
							if (st.strap_ss_n[b]) begin
								next_st.m66_oe[b] = cmd_mode_33[b];
							end
						end
						default: begin
							next_st.pending[b] = st.pending[b];
						end
					endcase
				end
				// secondary reset pulls the slot reset bits low too
				if (sec_bus_reset[b]) begin
					next_st.rstn[b] = 4'h0;
				end
				next_st.clr_n[b] = ~sec_bus_reset[b];
				if (!st.strap_hp[b]) begin
					next_st.m66_oe[b] = 1'b0;
					next_st.hold_low[b] = 1'b0;
				end
				// single slot: pin floats while the slot is off, so the
				// card's own level can be seen; frame end overrides this
				if (!st.strap_ss_n[b] && !st.bus_drv[b]) begin
					next_st.m66_oe[b] = 1'b0;
				end
			end

			// outbound shifter, shared, bridge a served first
			case (st.ostate)
				OUT_IDLE: begin
					if (fall && (st.pending != 2'b00)) begin
						next_st.obr = ~st.pending[0];
						next_st.odat = out_bit(st, ~st.pending[0], 5'd0);
						next_st.ocnt = 5'd1;
						next_st.ostate = OUT_SHIFT;
					end
				end
				OUT_SHIFT: begin
					if (fall) begin
						if (st.ocnt == `HP_OUT_LEN) begin
							next_st.odat = 1'b0;
							next_st.strobe[st.obr] = 1'b1;
							next_st.ostate = OUT_STROBE;
						end else begin
							next_st.odat = out_bit(st, st.obr, st.ocnt);
							next_st.ocnt = st.ocnt + 5'd1;
						end
					end
				end
				OUT_STROBE: begin
					if (fall) begin
						next_st.strobe = 2'b00;
						next_st.pending[st.obr] = 1'b0;
						next_st.ostate = OUT_IDLE;
						// single slot: device is the bus isolation
						if (!st.strap_ss_n[st.obr]) begin
							next_st.hold_low[st.obr] =
							  ~st.pwr[st.obr][0];
							next_st.bus_drv[st.obr] =
							  st.busen[st.obr][0];
							// pin floats until enable, low with clken in 33 MHz mode
							next_st.m66_oe[st.obr] = st.mode33[st.obr]
							  & st.clken[st.obr][0];
						end
					end
				end
				default: begin
					next_st.ostate = OUT_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// ------------------------------------------------------------
	// outputs, all straight from the state register except m66en_out, tied low
	// ------------------------------------------------------------
	// own capability pins are never sampled here
	assign hp_serial_out_data         = st.odat;
	assign hp_serial_out_data_oe      = st.pins_oe;
	assign hp_serial_in_load_n        = st.load_n;
	assign hp_serial_in_load_n_oe     = st.pins_oe;
	assign hp_serial_in_clock         = st.sclk;
	assign hp_serial_in_clock_oe      = st.pins_oe;
	assign hp_serial_out_clock        = st.sclk;
	assign output_latch_strobe        = st.strobe;
	assign slot_reset_latch_strobe    = st.strobe;
	assign slot_reset_latch_clear_n   = st.clr_n;
	assign cmd_busy                   = st.pending;
	assign m66en_out                  = 2'b00;
	assign m66en_oe                   = st.m66_oe;
	assign slot_signals_hold_low      = st.hold_low;
	assign slot_bus_drive_en          = st.bus_drv;
	assign hp_enabled                 = st.strap_hp;
	assign single_slot_strap_status_n = st.strap_ss_n;
	assign slot_prsnt1_n              = st.prsnt1_n;
	assign slot_prsnt2_n              = st.prsnt2_n;
	assign slot_66mhz_capability      = st.cap66;
	assign slot_pcix_capability       = st.pcix;
	assign status_update              = st.upd;

endmodule : hp_slot_ctrl

// >>> bench/hp_slot_ctrl_props.sv
// checker for the hot plug slot controller ports.
// assumes bridge a strapped multi-slot and bridge b single-slot.
`timescale 1ns/100ps
module hp_slot_ctrl_props (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst,
	// command ports
	input wire logic [1:0]         cmd_valid,
	input hp_slot_pkg::cmd_e [1:0] cmd_code,
	input wire logic [1:0]         cmd_mode_33,
	input wire logic [1:0]         cmd_busy,
	// pins and status
	input wire logic [1:0]         m66en_out,
	input wire logic [1:0]         m66en_oe,
	input wire logic [1:0]         output_latch_strobe,
	input wire logic [1:0]         slot_reset_latch_strobe,
	input wire logic               hp_serial_in_clock,
	input wire logic               hp_serial_out_clock,
	input wire logic [1:0]         sec_bus_reset,
	input wire logic [1:0]         slot_reset_latch_clear_n,
	input wire logic [1:0]         slot_bus_drive_en,
	input wire logic [1:0]         hp_enabled,
	input wire logic [1:0]         single_slot_strap_status_n
);
	import hp_slot_pkg::*;
	// --------------------------------------------------------
	// properties, all on the bridge clock
	// --------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// a request the port accepts on bridge a
	logic take0;
	assign take0 = cmd_valid[0] && hp_enabled[0] && !cmd_busy[0];
	a_busy_after_cmd: assert property (
		take0 && cmd_code[0] inside {CMD_POWER_ONLY, CMD_SLOT_ENABLE,
		CMD_SLOT_DISABLE} |-> ##[1:2] cmd_busy[0])
		else $error("busy missing after command");
	a_busy_ends_strobe: assert property (
		$fell(cmd_busy[0]) |-> $fell(output_latch_strobe[0]))
		else $error("busy ended apart from strobe");
	a_strobe_in_busy: assert property (
		output_latch_strobe[0] |-> cmd_busy[0])
		else $error("strobe outside busy");
	a_strobes_pair: assert property (
		output_latch_strobe == slot_reset_latch_strobe)
		else $error("latch strobes differ");
	a_strobe_width: assert property (
		$rose(output_latch_strobe[0]) |->
		output_latch_strobe[0] [*6] ##1 !output_latch_strobe[0])
		else $error("strobe not one serial period");
	a_sclk_shape: assert property (
		$rose(hp_serial_in_clock) |-> hp_serial_in_clock [*3]
		##1 !hp_serial_in_clock [*3] ##1 hp_serial_in_clock)
		else $error("serial clock period wrong");
	a_clocks_same: assert property (
		hp_serial_out_clock == hp_serial_in_clock)
		else $error("serial clocks differ");
	a_speed_multi: assert property (
		take0 && single_slot_strap_status_n[0] && cmd_code[0] ==
		CMD_SET_SPEED |=> m66en_oe[0] == $past(cmd_mode_33[0]))
		else $error("speed command not applied at once");
	a_speed_single: assert property (
		cmd_valid[1] && !cmd_busy[1] && !single_slot_strap_status_n[1]
		&& cmd_code[1] == CMD_SET_SPEED |=> $stable(m66en_oe[1]))
		else $error("single-slot speed command moved pin");
	a_open_drain: assert property (
		m66en_out == 2'h0)
		else $error("66 MHz pin driven high");
	a_refused_idle: assert property (
		(cmd_busy & ~hp_enabled) == 2'h0)
		else $error("busy on bridge without hot plug");
	a_clear_follows: assert property (
		!$past(rst) |-> slot_reset_latch_clear_n == ~$past(sec_bus_reset))
		else $error("latch clear not following bus reset");
	c_cmd_done: cover property ($fell(cmd_busy[0]));
	c_single_on: cover property ($rose(slot_bus_drive_en[1]));
	c_bus_reset: cover property ($fell(slot_reset_latch_clear_n[0]));
endmodule : hp_slot_ctrl_props

bind hp_slot_ctrl hp_slot_ctrl_props u_props (.clk, .rst, .cmd_valid,
	.cmd_code, .cmd_mode_33, .cmd_busy, .m66en_out, .m66en_oe,
	.output_latch_strobe, .slot_reset_latch_strobe, .hp_serial_in_clock,
	.hp_serial_out_clock, .sec_bus_reset, .slot_reset_latch_clear_n,
	.slot_bus_drive_en, .hp_enabled, .single_slot_strap_status_n);

// >>> bench/hp_power_ctrl_model.sv
// behavioural model of the external dual-slot power controllers.
// assumes serial wires already resolved from the pin enables.
`timescale 1ns/100ps
module hp_power_ctrl_model #(
	parameter logic [1:0][3:0] PRES = 8'h6a,
	parameter logic [1:0][3:0] CAP  = 8'h39
) (
	// shared serial wires
	input  wire logic             sclk,
	input  wire logic             oclk,
	input  wire logic             ld_n,
	input  wire logic             sod,
	// per-bridge wires
	input  wire logic [1:0]       olc,
	input  wire logic [1:0]       orlc,
	input  wire logic [1:0]       clr_n,
	output logic      [1:0]       sid,
	// latched slot controls
	output logic      [1:0][29:0] out_latch,
	output logic      [1:0][29:0] rst_latch
);
	int pos = 0;
	int s;
	logic ch = 1'b0;
	logic [29:0] sh = '0;
	// block position from the load marker; chan bit at count 1
	always @(posedge sclk) begin
		if (!ld_n && (pos == 0 || pos > 3)) pos <= 1;
		else if (pos != 0) pos <= pos + 1;
		if (pos == 1) ch <= ld_n;
	end
	// one level per slot field, so a skew of one bit is absorbed
	always_comb begin
		s = (pos - 4) / 8;
		for (int b = 0; b < 2; b++)
			sid[b] = (pos < 4 || s > 3) ? 1'b1 : ch ? CAP[b][s] : PRES[b][s];
	end
	// outbound shift on the rising serial clock
	always @(posedge oclk) sh <= {sh[28:0], sod};
	for (genvar b = 0; b < 2; b++) begin : g_br
		initial out_latch[b] = '0;
		always @(posedge olc[b]) out_latch[b] <= sh;
		// reset latches cleared while the bus reset is held
		always @(posedge orlc[b] or negedge clr_n[b])
			if (!clr_n[b]) rst_latch[b] <= '0;
			else rst_latch[b] <= sh;
	end
endmodule : hp_power_ctrl_model

// >>> bench/hp_slot_ctrl_test.sv
// self-checking bench for the hot plug slot controller.
// assumes the power controller model and the bound checker.
`timescale 1ns/100ps
module hp_slot_ctrl_test;
	import hp_slot_pkg::*;
	localparam logic [1:0][3:0] PRES = 8'h6a;
	localparam logic [1:0][3:0] CAP  = 8'h39;
	logic clk = 1'b0;
	logic rst = 1'b1;
	// straps: both hot plug, only bridge b single-slot
	logic strap_a = 1'b1;
	logic strap_b = 1'b1;
	logic ss_a_n  = 1'b1;
	logic g2      = 1'b0;
	logic sod, sod_oe, ld_n, ld_oe, sic, sic_oe, soc;
	// strap resistors show while the pins are released
	wire sod_w = sod_oe ? sod : strap_a;
	wire ld_w  = ld_oe ? ld_n : strap_b;
	wire sic_w = sic_oe ? sic : ss_a_n;
	logic [1:0] sid, olc, orlc, clr_n, busy, m66o, m66oe, hold, bdrv;
	logic [1:0] hpen, sss_n, supd;
	logic [1:0] sbr = 2'h0;
	logic [1:0] cmd_valid = 2'h0;
	logic [1:0] cmd_mode_33 = 2'h0;
	cmd_e [1:0] cmd_code = '{CMD_NONE, CMD_NONE};
	logic [1:0][1:0] cmd_slot = '0;
	logic [1:0][3:0] p1, p2, c66;
	logic [1:0][3:0][1:0] pcx;
	logic [1:0][29:0] ol, rl;
	int mismatches = 0;
	int n_checks = 0;

	hp_slot_ctrl uut (.clk, .rst, .hp_serial_out_data_in(sod_w),
		.hp_serial_out_data(sod), .hp_serial_out_data_oe(sod_oe),
		.hp_serial_in_load_n_in(ld_w), .hp_serial_in_load_n(ld_n),
		.hp_serial_in_load_n_oe(ld_oe), .hp_serial_in_clock_in(sic_w),
		.hp_serial_in_clock(sic), .hp_serial_in_clock_oe(sic_oe),
		.hp_serial_out_clock(soc), .bridge_b_grant2_strap(g2),
		.hp_serial_in_data(sid), .output_latch_strobe(olc),
		.slot_reset_latch_strobe(orlc), .sec_bus_reset(sbr),
		.slot_reset_latch_clear_n(clr_n), .cmd_valid, .cmd_code,
		.cmd_slot, .cmd_mode_33, .cmd_busy(busy), .m66en_out(m66o),
		.m66en_oe(m66oe), .slot_signals_hold_low(hold),
		.slot_bus_drive_en(bdrv), .hp_enabled(hpen),
		.single_slot_strap_status_n(sss_n), .slot_prsnt1_n(p1),
		.slot_prsnt2_n(p2), .slot_66mhz_capability(c66),
		.slot_pcix_capability(pcx), .status_update(supd));
	hp_power_ctrl_model #(.PRES(PRES), .CAP(CAP)) pc (.sclk(sic_w),
		.oclk(soc), .ld_n(ld_w), .sod(sod_w), .olc, .orlc, .clr_n,
		.sid, .out_latch(ol), .rst_latch(rl));

	// ----------------------------------------------------
	// helpers
	// ----------------------------------------------------
	initial forever #12.5 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// one-cycle request, driven on the falling edge
	task automatic send(input int b, input cmd_e c, input int s,
		input logic m);
		@(negedge clk);
		cmd_valid[b] = 1'b1;
		cmd_code[b] = c;
		cmd_slot[b] = 2'(s);
		cmd_mode_33[b] = m;
		@(negedge clk);
		cmd_valid[b] = 1'b0;
	endtask : send
	task automatic wait_idle(input int b);
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (busy[b] !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("cmd_busy", 0, busy[b]);
	endtask : wait_idle
	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------
	// scenarios
	// ----------------------------------------------------
	task automatic t_reset();
		rst = 1'b1;
		repeat (10) @(negedge clk);
		chk("m66en_oe", 2'h3, m66oe);
		chk("hold_low", 2'h3, hold);
		rst = 1'b0;
		@(negedge clk);
		chk("hp_enabled", {strap_b, strap_a}, hpen);
		chk("strap_status", {g2, ss_a_n}, sss_n);
		chk("m66en_oe a", strap_a, m66oe[0]);
		chk("m66en_oe b", 0, m66oe[1]);
	endtask : t_reset
	// status of both channels decoded into the slot fields
	task automatic t_inbound();
		int n0, n1, k;
		n0 = 0;
		n1 = 0;
		k = 0;
		while ((n0 < 3 || n1 < 3) && k < 3000) begin
			@(negedge clk);
			n0 += int'(supd[0] === 1'b1);
			n1 += int'(supd[1] === 1'b1);
			k++;
		end
		chk("status blocks", 1, k < 3000);
		for (int b = 0; b < 2; b++)
			for (int s = 0; s < 4; s++) begin
				chk("prsnt1_n", PRES[b][s], p1[b][s]);
				chk("prsnt2_n", PRES[b][s], p2[b][s]);
				chk("66mhz_cap", CAP[b][s], c66[b][s]);
				chk("pcix_cap", {2{CAP[b][s]}}, pcx[b][s]);
			end
	endtask : t_inbound
	// bridge a: speed at once, a refused request, then enable
	task automatic t_multi();
		send(0, CMD_SET_SPEED, 0, 1'b0);
		chk("m66en_oe a", 0, m66oe[0]);
		send(0, CMD_SET_SPEED, 0, 1'b1);
		chk("m66en_oe a", 1, m66oe[0]);
		chk("cmd_busy a", 0, busy[0]);
		send(0, CMD_POWER_ONLY, 2, 1'b1);
		repeat (2) @(negedge clk);
		send(0, CMD_SLOT_ENABLE, 1, 1'b1);
		wait_idle(0);
		chk("slot2 power", 1, ol[0][21]);
		chk("slot2 clken", 0, ol[0][20]);
		chk("slot1 clken", 0, ol[0][12]);
		send(0, CMD_SLOT_ENABLE, 2, 1'b1);
		wait_idle(0);
		chk("slot2 clken", 1, ol[0][20]);
		chk("slot2 busen", 1, ol[0][19]);
		chk("slot2 led", 1, ol[0][17]);
		chk("slot2 reset_n", 1, rl[0][18]);
	endtask : t_multi
	// bridge b: the device isolates its one slot itself
	task automatic t_single();
		chk("hold_low b", 1, hold[1]);
		chk("bus_drv b", 0, bdrv[1]);
		send(1, CMD_POWER_ONLY, 0, 1'b1);
		wait_idle(1);
		chk("b slot0 power", 1, ol[1][5]);
		chk("66mhz_cap b", CAP[1][0], c66[1][0]);
		send(1, CMD_SET_SPEED, 0, 1'b1);
		chk("m66en_oe b", 0, m66oe[1]);
		send(1, CMD_SLOT_ENABLE, 0, 1'b1);
		wait_idle(1);
		chk("bus_drv b", 1, bdrv[1]);
		chk("hold_low b", 0, hold[1]);
		chk("m66en_oe b", 1, m66oe[1]);
		send(1, CMD_SLOT_DISABLE, 0, 1'b1);
		wait_idle(1);
		chk("bus_drv b", 0, bdrv[1]);
		chk("m66en_oe b", 0, m66oe[1]);
		chk("b slot0 clken", 0, ol[1][4]);
	endtask : t_single
	task automatic t_bus_reset();
		@(negedge clk);
		sbr[0] = 1'b1;
		repeat (2) @(negedge clk);
		chk("latch clear", 2'h2, clr_n);
		chk("reset latch", 0, rl[0][18]);
		sbr[0] = 1'b0;
		repeat (2) @(negedge clk);
		chk("latch clear", 2'h3, clr_n);
	endtask : t_bus_reset
	// bridge a strapped off: commands there are dropped
	task automatic t_refused();
		strap_a = 1'b0;
		t_reset();
		send(0, CMD_POWER_ONLY, 0, 1'b0);
		repeat (3) @(negedge clk);
		chk("cmd_busy a", 0, busy[0]);
	endtask : t_refused

	// ----------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------
	initial begin
		t_reset();
		t_inbound();
		t_multi();
		t_single();
		t_bus_reset();
		t_refused();
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
endmodule : hp_slot_ctrl_test
